// *** core/slm_i2c_slave.sv ***
`timescale 1ns/100ps
// Byte-wide I2C target: pointer write, data writes and auto-increment reads
module slm_i2c_slave (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oen,
    output logic [7:0]      reg_addr,
    output logic [7:0]      wr_data,
    output logic            wr_stb,
    input  wire logic [7:0] rd_data
);
    // Three-stage synchronisers; the first stage feeds only the second
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic       scl_q_r;
    logic       sda_q_r;
    logic       scl_d_r;
    logic       sda_d_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[1:0], scl_in};
            sda_s_r <= {sda_s_r[1:0], sda_in};
            // Change counts only once stages two and three agree
            if (scl_s_r[1] == scl_s_r[2]) scl_q_r <= scl_s_r[2];
            if (sda_s_r[1] == sda_s_r[2]) sda_q_r <= sda_s_r[2];
            scl_d_r <= scl_q_r;
            sda_d_r <= sda_q_r;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = scl_q_r & ~scl_d_r;
    assign scl_fall = ~scl_q_r & scl_d_r;
    assign start_c  = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
    assign stop_c   = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;

    ////////////////////////////////////////////////////////////////////
    // Byte engine
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic       active_r;
    logic       is_read_r;
    logic       ack_r;
    logic       first_r;
    logic       ptr_set_r;
    logic       drive_low_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_r   <= 4'h0;
            shift_r     <= 8'h00;
            active_r    <= 1'b0;
            is_read_r   <= 1'b0;
            ack_r       <= 1'b0;
            first_r     <= 1'b0;
            ptr_set_r   <= 1'b0;
            drive_low_r <= 1'b0;
            reg_addr    <= 8'h00;
            wr_data     <= 8'h00;
            wr_stb      <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            // Step the pointer only after the strobe cycle, so the write lands at its own offset
            if (wr_stb) reg_addr <= reg_addr + 8'h01;
            if (start_c) begin
                active_r    <= 1'b1;
                first_r     <= 1'b1;
                is_read_r   <= 1'b0;
                bit_cnt_r   <= 4'h0;
                drive_low_r <= 1'b0;
            end else if (stop_c) begin
                active_r    <= 1'b0;
                drive_low_r <= 1'b0;
            end else if (active_r && scl_rise && bit_cnt_r < 4'h8) begin
                shift_r   <= {shift_r[6:0], sda_q_r};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (active_r && scl_rise) begin
                // Ninth clock: master ack on reads ends the stream on a NAK
                if (is_read_r && sda_q_r) active_r <= 1'b0;
                bit_cnt_r <= 4'h0;
            end else if (active_r && scl_fall && bit_cnt_r == 4'h8) begin
                ack_r <= 1'b0;
                if (first_r) begin
                    first_r   <= 1'b0;
                    ptr_set_r <= 1'b0;
                    if (shift_r[7:1] == slm_pkg::MON_I2C_ADDR) begin
                        ack_r       <= 1'b1;
                        is_read_r   <= shift_r[0];
                        drive_low_r <= 1'b1;
                        shift_r     <= rd_data;
                    end else begin
                        active_r    <= 1'b0;
                        drive_low_r <= 1'b0;
                    end
                end else if (!is_read_r) begin
                    drive_low_r <= 1'b1;
                    if (!ptr_set_r) begin
                        reg_addr  <= shift_r;
                        ptr_set_r <= 1'b1;
                    end else begin
                        wr_data  <= shift_r;
                        wr_stb   <= 1'b1;
                    end
                end else begin
                    // Advance now so the next byte is fetched from the new offset
                    drive_low_r <= 1'b0;
                    reg_addr    <= reg_addr + 8'h01;
                end
            end else if (active_r && scl_fall && bit_cnt_r == 4'h0) begin
                // After ack slot: release or load the next read byte
                if (is_read_r) begin
                    shift_r     <= ack_r ? shift_r : rd_data;
                    drive_low_r <= ack_r ? ~shift_r[7] : ~rd_data[7];
                end else begin
                    drive_low_r <= 1'b0;
                end
                ack_r <= 1'b0;
            end else if (active_r && is_read_r && scl_fall && bit_cnt_r < 4'h8) begin
                drive_low_r <= ~shift_r[7];
            end else if (active_r && is_read_r && scl_fall) begin
                drive_low_r <= 1'b0;
            end
        end
    end

    // Open drain: enable is low while pulling the line low
    assign sda_oen = ~drive_low_r;
endmodule

// *** core/slm_monitor.sv ***
`timescale 1ns/100ps
// Contract
// - Sample rail every 16 us normally
// - Fluctuation: 8 us sampling, watch window
// - Filter drops so spikes never switch
// - Dangerous after window: enable boost immediately
// - Hold backup until stable, then revert
// - Same monitoring for either power input
// - Record raw unfiltered sample, under 1 us
// - Monitoring registers read-only, writes ignored
// - Captured value held until next event
// - Latch trip voltage at 0x02 on loss
// - Registers answer at I2C address 0x69
// - Executing registers steer thresholds and timing
// - Auto-adjust command; no backup while running
// - Adjust failure: blink lights and beep
module slm_monitor #(
    parameter int NORMAL_TICKS = slm_pkg::NORMAL_TICKS,
    parameter int FAST_TICKS   = slm_pkg::FAST_TICKS,
    parameter int ALARM_BIT    = slm_pkg::ALARM_BIT
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] rail_level,
    output logic            sample_req,
    output logic            boost_en,
    output logic            led_blink,
    output logic            beep,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oen
);
    logic [7:0] reg_addr;
    logic [7:0] wr_data;
    logic       wr_stb;
    logic [7:0] rd_data;

    slm_i2c_slave u_i2c (
        .clock    (clock),
        .rstn     (rstn),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oen  (sda_oen),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .wr_stb   (wr_stb),
        .rd_data  (rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Executing registers
    logic [7:0] low_thresh_r;
    logic [7:0] ok_thresh_r;
    logic [7:0] window_r;
    logic [7:0] filter_r;
    logic       adj_start;
    slm_pkg::slm_state_t state_r;
    logic       adj_done;
    logic [7:0] adj_min_r;

    assign adj_start = wr_stb && reg_addr == slm_pkg::OFF_COMMAND
                       && wr_data == slm_pkg::CMD_AUTO_ADJUST;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            low_thresh_r <= slm_pkg::RST_LOW_THRESH;
            ok_thresh_r  <= slm_pkg::RST_OK_THRESH;
            window_r     <= slm_pkg::RST_WINDOW;
            filter_r     <= slm_pkg::RST_FILTER;
        end else if (adj_done) begin
            // Trip just below the worst dip seen while adjusting
            low_thresh_r <= adj_min_r - slm_pkg::AUTO_MARGIN;
            ok_thresh_r  <= adj_min_r;
        end else if (wr_stb) begin
            if (reg_addr == slm_pkg::OFF_LOW_THRESH) begin
                low_thresh_r <= wr_data;
            end else if (reg_addr == slm_pkg::OFF_OK_THRESH) begin
                ok_thresh_r <= wr_data;
            end else if (reg_addr == slm_pkg::OFF_WINDOW) begin
                window_r <= wr_data;
            end else if (reg_addr == slm_pkg::OFF_FILTER) begin
                filter_r <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Free-running time base; one rail input serves either supply path
    logic [15:0] tb_cnt_r;
    logic        tick;
    logic        fast;
    assign fast = state_r != slm_pkg::SLM_NORMAL;
    assign tick = tb_cnt_r == 16'h0000;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tb_cnt_r <= 16'h0000;
        end else if (tick) begin
            tb_cnt_r <= fast ? 16'(FAST_TICKS - 1) : 16'(NORMAL_TICKS - 1);
        end else begin
            tb_cnt_r <= tb_cnt_r - 16'h0001;
        end
    end

    // Converter strobe, then sample inside the one microsecond budget
    logic [7:0] smp_cnt_r;
    logic       smp_valid;
    logic [7:0] sample_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            smp_cnt_r <= 8'h00;
            sample_r  <= 8'h00;
        end else if (tick) begin
            smp_cnt_r <= 8'(slm_pkg::SAMPLE_CYCLES);
        end else if (smp_cnt_r != 8'h00) begin
            smp_cnt_r <= smp_cnt_r - 8'h01;
            if (smp_cnt_r == 8'h01) sample_r <= rail_level;
        end
    end
    assign sample_req = tick;
    assign smp_valid  = smp_cnt_r == 8'h01;

    ////////////////////////////////////////////////////////////////////
    // Monitor state machine
    logic       low_now;
    logic [7:0] win_cnt_r;
    logic [7:0] low_run_r;
    logic [7:0] pass_r;
    assign low_now  = rail_level < low_thresh_r;
    assign adj_done = state_r == slm_pkg::SLM_ADJUST && smp_valid
                      && pass_r == slm_pkg::AUTO_PASSES && adj_min_r >= slm_pkg::AUTO_MIN_LEVEL;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r   <= slm_pkg::SLM_NORMAL;
            win_cnt_r <= 8'h00;
            low_run_r <= 8'h00;
            pass_r    <= 8'h00;
            adj_min_r <= 8'hff;
        end else if (adj_start) begin
            state_r   <= slm_pkg::SLM_ADJUST;
            pass_r    <= 8'h00;
            adj_min_r <= 8'hff;
        end else if (smp_valid) begin
            case (state_r)
                slm_pkg::SLM_NORMAL: begin
                    if (low_now) begin
                        state_r   <= slm_pkg::SLM_WATCH;
                        win_cnt_r <= window_r;
                        low_run_r <= 8'h01;
                    end
                end
                slm_pkg::SLM_WATCH: begin
                    low_run_r <= low_now ? low_run_r + 8'h01 : 8'h00;
                    if (win_cnt_r == 8'h00) begin
                        // Only a sustained drop at window end is dangerous
                        state_r <= (low_run_r >= filter_r) ? slm_pkg::SLM_BACKUP
                                                           : slm_pkg::SLM_NORMAL;
                    end else begin
                        win_cnt_r <= win_cnt_r - 8'h01;
                    end
                end
                slm_pkg::SLM_BACKUP: begin
                    low_run_r <= (rail_level >= ok_thresh_r) ? low_run_r + 8'h01 : 8'h00;
                    if (rail_level >= ok_thresh_r && low_run_r >= filter_r) begin
                        state_r   <= slm_pkg::SLM_NORMAL;
                        low_run_r <= 8'h00;
                    end
                end
                slm_pkg::SLM_ADJUST: begin
                    pass_r <= pass_r + 8'h01;
                    if (rail_level < adj_min_r) adj_min_r <= rail_level;
                    if (pass_r == slm_pkg::AUTO_PASSES) begin
                        state_r <= (adj_min_r >= slm_pkg::AUTO_MIN_LEVEL)
                                   ? slm_pkg::SLM_NORMAL : slm_pkg::SLM_FAIL;
                    end
                end
                default: begin
                    state_r <= slm_pkg::SLM_FAIL;  // Stays until a new adjust command
                end
            endcase
        end
    end

    // Boost only in backup; never while adjusting
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            boost_en <= 1'b0;
        end else begin
            boost_en <= state_r == slm_pkg::SLM_BACKUP;
        end
    end

    // Failure alarm: slow toggle from a free counter
    logic [23:0] alarm_cnt_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            alarm_cnt_r <= 24'h000000;
            led_blink   <= 1'b0;
            beep        <= 1'b0;
        end else begin
            alarm_cnt_r <= alarm_cnt_r + 24'h000001;
            led_blink   <= state_r == slm_pkg::SLM_FAIL && alarm_cnt_r[ALARM_BIT];
            beep        <= state_r == slm_pkg::SLM_FAIL && alarm_cnt_r[ALARM_BIT - 4];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trip voltage capture; host writes never reach it
    logic [15:0] trip_volt_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trip_volt_r <= 16'h0000;
        end else if (smp_valid && state_r == slm_pkg::SLM_NORMAL && low_now) begin
            trip_volt_r <= {8'h00, rail_level};
        end
    end

    // Read mux: word at 0x02 is low byte then high byte
    always_comb begin
        if (reg_addr == slm_pkg::OFF_TRIP_VOLT) begin
            rd_data = trip_volt_r[7:0];
        end else if (reg_addr == slm_pkg::OFF_TRIP_VOLT + 8'h01) begin
            rd_data = trip_volt_r[15:8];
        end else if (reg_addr == slm_pkg::OFF_LOW_THRESH) begin
            rd_data = low_thresh_r;
        end else if (reg_addr == slm_pkg::OFF_OK_THRESH) begin
            rd_data = ok_thresh_r;
        end else if (reg_addr == slm_pkg::OFF_WINDOW) begin
            rd_data = window_r;
        end else if (reg_addr == slm_pkg::OFF_FILTER) begin
            rd_data = filter_r;
        end else if (reg_addr == slm_pkg::OFF_STATUS) begin
            rd_data = {5'h00, state_r};
        end else begin
            rd_data = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_no_boost_adjust: assert property (@(posedge clock) disable iff (!rstn)
        state_r == slm_pkg::SLM_ADJUST |=> !boost_en) else $error("boost during adjust");
    a_boost_follows_backup: assert property (@(posedge clock) disable iff (!rstn)
        state_r == slm_pkg::SLM_BACKUP |=> boost_en) else $error("boost not on in backup");
    a_tick_normal_period: assert property (@(posedge clock) disable iff (!rstn)
        tick && !fast |=> !tick [*5]) else $error("normal tick too soon");
    a_trip_held_value: assert property (@(posedge clock) disable iff (!rstn)
        !(smp_valid && state_r == slm_pkg::SLM_NORMAL && low_now) |=> $stable(trip_volt_r))
        else $error("trip voltage changed without loss");
    a_trip_write_ignored: assert property (@(posedge clock) disable iff (!rstn)
        wr_stb && reg_addr == slm_pkg::OFF_TRIP_VOLT && !smp_valid |=> $stable(trip_volt_r))
        else $error("host write changed trip voltage");
    a_watch_entry: assert property (@(posedge clock) disable iff (!rstn)
        smp_valid && state_r == slm_pkg::SLM_NORMAL && low_now && !adj_start
        |=> state_r == slm_pkg::SLM_WATCH) else $error("no watch on fluctuation");
    a_spike_filtered: assert property (@(posedge clock) disable iff (!rstn)
        state_r == slm_pkg::SLM_WATCH && low_run_r < filter_r && !adj_start
        |=> state_r != slm_pkg::SLM_BACKUP) else $error("spike caused backup");
    a_alarm_only_fail: assert property (@(posedge clock) disable iff (!rstn)
        led_blink |-> $past(state_r) == slm_pkg::SLM_FAIL) else $error("blink outside failure");
endmodule

// *** core/slm_pkg.sv ***
package slm_pkg;
    // Clock rate and sampling periods
    localparam int CLK_MHZ          = 125;
    localparam int NORMAL_PERIOD_US = 16;
    localparam int FAST_PERIOD_US   = 8;
    localparam int SAMPLE_TIME_NS   = 1000;
    localparam int NORMAL_TICKS     = NORMAL_PERIOD_US * CLK_MHZ;
    localparam int FAST_TICKS       = FAST_PERIOD_US * CLK_MHZ;
    // Raw sample must be taken just inside one microsecond
    localparam int SAMPLE_CYCLES    = (SAMPLE_TIME_NS * CLK_MHZ) / 1000 - 1;
    // I2C address of the monitoring page
    localparam logic [6:0] MON_I2C_ADDR = 7'h69;
    // Register offsets
    localparam logic [7:0] OFF_TRIP_VOLT   = 8'h02;
    localparam logic [7:0] OFF_LOW_THRESH  = 8'h10;
    localparam logic [7:0] OFF_OK_THRESH   = 8'h11;
    localparam logic [7:0] OFF_WINDOW      = 8'h12;
    localparam logic [7:0] OFF_FILTER      = 8'h13;
    localparam logic [7:0] OFF_COMMAND     = 8'h14;
    localparam logic [7:0] OFF_STATUS      = 8'h15;
    // Reset values of the executing parameters, tenths of a volt and ticks
    localparam logic [7:0] RST_LOW_THRESH  = 8'h2d;
    localparam logic [7:0] RST_OK_THRESH   = 8'h30;
    localparam logic [7:0] RST_WINDOW      = 8'h0f;
    localparam logic [7:0] RST_FILTER      = 8'h03;
    localparam logic [7:0] CMD_AUTO_ADJUST = 8'ha5;
    localparam logic [7:0] AUTO_MARGIN     = 8'h02;
    localparam logic [7:0] AUTO_MIN_LEVEL  = 8'h2a;
    localparam logic [7:0] AUTO_PASSES     = 8'h40;
    localparam int         ALARM_BIT       = 23;
    // Monitor states
    typedef enum logic [2:0] {
        SLM_NORMAL = 3'b000,
        SLM_WATCH  = 3'b001,
        SLM_BACKUP = 3'b010,
        SLM_ADJUST = 3'b011,
        SLM_FAIL   = 3'b100
    } slm_state_t;
endpackage

// *** testbench/slm_host_model.sv ***
`timescale 1ns/100ps
// I2C controller standing in for the host processor
module slm_host_model #(
    parameter int Q = 6
) (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl_out,
    output logic      sda_rel
);
    // Bus idles released; the wire pull-up gives high
    initial begin
        scl_out = 1'b1;
        sda_rel = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // Quarter bit; data moves well after SCL falls, past the sync lag
    task automatic step();
        repeat (Q) @(negedge clock);
    endtask
    // Start, also used as repeated start
    task automatic start_cond();
        sda_rel = 1'b1;
        step();
        scl_out = 1'b1;
        step();
        sda_rel = 1'b0;
        step();
        scl_out = 1'b0;
        step();
    endtask
    task automatic stop_cond();
        sda_rel = 1'b0;
        step();
        scl_out = 1'b1;
        step();
        sda_rel = 1'b1;
        step();
    endtask
    // One bit out, wire level sampled late in the high phase
    task automatic put_bit(input logic b, output logic got);
        sda_rel = b;
        step();
        scl_out = 1'b1;
        step();
        step();
        got = sda_line;
        scl_out = 1'b0;
        step();
    endtask
    // Eight bits plus acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(ack_in, ack);
    endtask
    ////////////////////////////////////////////////////////////
    // One register per transaction, so changes land one at a time
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] val, output logic ok);
        logic [7:0] rx;
        logic       a0;
        logic       a1;
        logic       a2;
        start_cond();
        xfer({dev, 1'b0}, 1'b1, rx, a0);
        xfer(ptr, 1'b1, rx, a1);
        xfer(val, 1'b1, rx, a2);
        stop_cond();
        ok = !(a0 | a1 | a2);
    endtask
    // Pointer write, repeated start, two bytes low first, NAK on last
    task automatic rd(input logic [7:0] ptr, output logic [15:0] val, output logic ok);
        logic [7:0] rx;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        start_cond();
        xfer({slm_pkg::MON_I2C_ADDR, 1'b0}, 1'b1, rx, a0);
        xfer(ptr, 1'b1, rx, a1);
        start_cond();
        xfer({slm_pkg::MON_I2C_ADDR, 1'b1}, 1'b1, rx, a2);
        xfer(8'hff, 1'b0, val[7:0], a3);
        xfer(8'hff, 1'b1, val[15:8], a3);
        stop_cond();
        ok = !(a0 | a1 | a2);
    endtask
endmodule

// *** testbench/supply_loss_monitor_test.sv ***
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module supply_loss_monitor_test;
    // Short tick counts keep the run brief but longer than the sample delay
    localparam int NT = 400;
    localparam int FT = 200;
    // Fast alarm toggles so blinking shows within the run
    localparam int AB = 6;
    logic       clock;
    logic       rstn;
    logic [7:0] rail_level;
    logic       sample_req;
    logic       boost_en;
    logic       led_blink;
    logic       beep;
    logic       scl;
    logic       sda_oen;
    logic       host_rel;
    wire  logic sda_line;
    logic       ok;
    int         num_errors = 0;
    int         check_count = 0;
    int         boost_cnt = 0;
    int         alarm_cnt = 0;
    // Open-drain wire with pull-up
    assign sda_line = sda_oen & host_rel;
    slm_monitor #(
        .NORMAL_TICKS (NT),
        .FAST_TICKS   (FT),
        .ALARM_BIT    (AB)
    ) i_dut (
        .clock      (clock),
        .rstn       (rstn),
        .rail_level (rail_level),
        .sample_req (sample_req),
        .boost_en   (boost_en),
        .led_blink  (led_blink),
        .beep       (beep),
        .scl_in     (scl),
        .sda_in     (sda_line),
        .sda_oen    (sda_oen)
    );
    slm_host_model i_host (
        .clock    (clock),
        .sda_line (sda_line),
        .scl_out  (scl),
        .sda_rel  (host_rel)
    );
    initial clock = 1'b0;
    always #4 clock = ~clock;
    // Cycles with backup or alarm outputs active
    always @(posedge clock) begin
        if (boost_en === 1'b1) boost_cnt++;
        if (led_blink === 1'b1 || beep === 1'b1) alarm_cnt++;
    end
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_is(input logic [7:0] ptr, input logic [15:0] exp, input logic word);
        logic [15:0] v;
        logic        a;
        i_host.rd(ptr, v, a);
        `CHK(a, 1'b1)
        if (word) begin
            `CHK(v, exp)
        end else begin
            `CHK(v[7:0], exp[7:0])
        end
    endtask
    // Bounded wait for the backup output to reach a level
    task automatic wait_boost(input logic lvl, input int lim);
        int n;
        n = 0;
        while (boost_en !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
        `CHK(boost_en, lvl)
    endtask
    // Gap between two consecutive sampling pulses
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        while (sample_req !== 1'b1 && n < 3 * NT) begin
            @(negedge clock);
            n++;
        end
        gap = 0;
        do begin
            @(negedge clock);
            gap++;
        end while (sample_req !== 1'b1 && gap < 3 * NT);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic test_reset();
        int g;
        `CHK(boost_en, 1'b0)
        `CHK(sda_oen, 1'b1)
        reg_is(slm_pkg::OFF_LOW_THRESH, {8'h00, slm_pkg::RST_LOW_THRESH}, 1'b0);
        reg_is(slm_pkg::OFF_OK_THRESH, {8'h00, slm_pkg::RST_OK_THRESH}, 1'b0);
        reg_is(slm_pkg::OFF_WINDOW, {8'h00, slm_pkg::RST_WINDOW}, 1'b0);
        reg_is(slm_pkg::OFF_FILTER, {8'h00, slm_pkg::RST_FILTER}, 1'b0);
        reg_is(slm_pkg::OFF_STATUS, 16'h0000, 1'b0);
        tick_gap(g);
        `CHK(g, NT)
        $display("test reset and period done");
    endtask
    // One low sample between good ones must not switch to battery
    task automatic test_spike();
        int g;
        int b0;
        b0 = boost_cnt;
        tick_gap(g);
        rail_level = 8'h28;
        repeat (140) @(negedge clock);
        rail_level = 8'h32;
        tick_gap(g);
        `CHK(g, FT)
        reg_is(slm_pkg::OFF_STATUS, 16'h0001, 1'b0);
        reg_is(slm_pkg::OFF_TRIP_VOLT, 16'h0028, 1'b1);
        repeat (4000) @(negedge clock);
        reg_is(slm_pkg::OFF_STATUS, 16'h0000, 1'b0);
        `CHK(boost_cnt, b0)
        $display("test spike done");
    endtask
    // Sustained loss, host pokes during backup, then recovery
    task automatic test_loss();
        rail_level = 8'h20;
        wait_boost(1'b1, 6000);
        reg_is(slm_pkg::OFF_STATUS, 16'h0002, 1'b0);
        reg_is(slm_pkg::OFF_TRIP_VOLT, 16'h0020, 1'b1);
        i_host.wr(slm_pkg::MON_I2C_ADDR, slm_pkg::OFF_TRIP_VOLT, 8'h77, ok);
        reg_is(slm_pkg::OFF_TRIP_VOLT, 16'h0020, 1'b1);
        i_host.wr(7'h6a, slm_pkg::OFF_WINDOW, 8'h01, ok);
        `CHK(ok, 1'b0)
        `CHK(boost_en, 1'b1)
        rail_level = 8'h32;
        wait_boost(1'b0, 2000);
        reg_is(slm_pkg::OFF_STATUS, 16'h0000, 1'b0);
        reg_is(slm_pkg::OFF_TRIP_VOLT, 16'h0020, 1'b1);
        `CHK(alarm_cnt, 0)
        $display("test loss done");
    endtask
    // A short window must switch well before the default one could
    task automatic test_window();
        i_host.wr(slm_pkg::MON_I2C_ADDR, slm_pkg::OFF_WINDOW, 8'h02, ok);
        `CHK(ok, 1'b1)
        reg_is(slm_pkg::OFF_WINDOW, 16'h0002, 1'b0);
        rail_level = 8'h20;
        wait_boost(1'b1, 1600);
        rail_level = 8'h32;
        wait_boost(1'b0, 2000);
        i_host.wr(slm_pkg::MON_I2C_ADDR, slm_pkg::OFF_WINDOW, slm_pkg::RST_WINDOW, ok);
        $display("test window done");
    endtask
    // Poor supply: adjust fails, and no backup is offered meanwhile
    task automatic test_adjust();
        int b0;
        int a0;
        b0 = boost_cnt;
        a0 = alarm_cnt;
        rail_level = 8'h20;
        i_host.wr(slm_pkg::MON_I2C_ADDR, slm_pkg::OFF_COMMAND, slm_pkg::CMD_AUTO_ADJUST, ok);
        `CHK(ok, 1'b1)
        repeat (68 * FT) @(negedge clock);
        reg_is(slm_pkg::OFF_STATUS, 16'h0004, 1'b0);
        `CHK(alarm_cnt > a0, 1'b1)
        `CHK(boost_cnt, b0)
        rail_level = 8'h32;
        i_host.wr(slm_pkg::MON_I2C_ADDR, slm_pkg::OFF_COMMAND, slm_pkg::CMD_AUTO_ADJUST, ok);
        repeat (68 * FT) @(negedge clock);
        a0 = alarm_cnt;
        reg_is(slm_pkg::OFF_STATUS, 16'h0000, 1'b0);
        reg_is(slm_pkg::OFF_LOW_THRESH, {8'h00, 8'h32 - slm_pkg::AUTO_MARGIN}, 1'b0);
        reg_is(slm_pkg::OFF_OK_THRESH, 16'h0032, 1'b0);
        `CHK(boost_cnt, b0)
        `CHK(alarm_cnt, a0)
        $display("test adjust done");
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence, inputs moved on falling edges
    initial begin
        rstn = 1'b0;
        rail_level = 8'h32;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        repeat (8) @(negedge clock);
        test_reset();
        test_spike();
        test_loss();
        test_window();
        test_adjust();
        print_verdict();
    end
    // Watchdog well beyond the expected run of about 60k cycles
    initial begin
        repeat (95000) @(posedge clock);
        num_errors++;
        print_verdict();
    end
endmodule
